// ### sim/flc_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module flc_core_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_push_go,
  input wire logic i_pop_go,
  input wire logic i_slow,
  input wire logic [15:0] i_push_lim,
  output logic o_push_valid,
  output logic [7:0] o_push_data,
  input wire logic i_push_ready,
  input wire logic i_pop_valid,
  input wire logic [7:0] i_pop_data,
  output logic o_pop_ready,
  output logic [15:0] o_n_push,
  output logic [15:0] o_n_pop,
  output logic [15:0] o_n_bad
);
  logic tog_q;
  logic [7:0] last_q;
  // valid holds until taken; idle data shows the inverse of the last byte
  assign o_push_valid = i_push_go && (o_n_push < i_push_lim);
  assign o_push_data = o_push_valid ? (o_n_push[7:0] ^ 8'h5A) : ~last_q;
  // slow mode stalls the drain every other cycle
  assign o_pop_ready = i_pop_go && (!i_slow || tog_q);
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      tog_q <= 1'h0;
      last_q <= 8'h00;
      o_n_push <= 16'h0;
      o_n_pop <= 16'h0;
      o_n_bad <= 16'h0;
    end
    else
    begin
      tog_q <= !tog_q;
      if (o_push_valid && i_push_ready)
      begin
        last_q <= o_push_data;
        o_n_push <= o_n_push + 16'h1;
      end
      if (i_pop_valid && o_pop_ready)
      begin
        o_n_pop <= o_n_pop + 16'h1;
        if (i_pop_data !== (o_n_pop[7:0] ^ 8'h5A))
          o_n_bad <= o_n_bad + 16'h1;
      end
    end
  end
endmodule : flc_core_model

`default_nettype wire

// ### sim/flc_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module flc_monitor
  import flc_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic [flc_pkg::FLC_AW-1:0] I_AWADDR,
  input wire logic I_WVALID,
  input wire logic O_WREADY,
  input wire logic [flc_pkg::FLC_DW-1:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic [flc_pkg::FLC_AW-1:0] I_ARADDR,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [flc_pkg::FLC_DW-1:0] O_RDATA,
  input wire logic [1:0] O_RRESP,
  input wire logic O_CORE_POP_VALID
);
  import flc_pkg::*;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_NRST);

  // ------------------------------------------------
  // request decode
  // ------------------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    return a inside {FLC_ADDR_SETTINGS, FLC_ADDR_THRESH, FLC_ADDR_FILL, FLC_ADDR_DATA, FLC_ADDR_IRQ_STAT,
      FLC_ADDR_IRQ_MASK};
  endfunction : mapped
  logic ar_take;
  assign ar_take = I_ARVALID && O_ARREADY;
  sequence s_wr_take;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
  endsequence
  sequence s_clear_take;
    s_wr_take ##0 (I_AWADDR == FLC_ADDR_SETTINGS && I_WSTRB[0] && I_WDATA[FLC_BIT_CLEAR]);
  endsequence

  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  property p_wr_answer; s_wr_take |-> ##[1:2] O_BVALID; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
  property p_wr_unmapped; s_wr_take ##0 !mapped(I_AWADDR) |-> ##[1:2] (O_BVALID && O_BRESP == FLC_RESP_SLVERR); endproperty
  a_wr_unmapped: assert property (p_wr_unmapped) else $error("unmapped write not refused");
  property p_b_hold; O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_rd_answer; ar_take |=> O_RVALID; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");
  property p_rd_hold; O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA) && $stable(O_RRESP); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
  property p_ar_refuse; O_RVALID |-> !O_ARREADY; endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while busy");
  property p_rd_unmapped; ar_take && !mapped(I_ARADDR) |=> O_RRESP == FLC_RESP_SLVERR && O_RDATA == 32'h0; endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not refused");
  property p_byte_rd; ar_take && mapped(I_ARADDR) |=> O_RRESP == FLC_RESP_OKAY && O_RDATA[31:8] == 24'h0; endproperty
  a_byte_rd: assert property (p_byte_rd) else $error("byte register read malformed");
  property p_clear_rd; ar_take && I_ARADDR == FLC_ADDR_SETTINGS |=> !O_RDATA[FLC_BIT_CLEAR] && !O_RDATA[3]; endproperty
  a_clear_rd: assert property (p_clear_rd) else $error("clear bit reads one");
  property p_clear_pop; s_clear_take |-> ##[1:2] !O_CORE_POP_VALID; endproperty
  a_clear_pop: assert property (p_clear_pop) else $error("buffer not empty after clear");
endmodule : flc_monitor

bind flc_top flc_monitor u_flc_monitor (
  .I_CLK(I_CLK), .I_NRST(I_NRST), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_AWADDR(I_AWADDR),
  .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB), .O_BVALID(O_BVALID),
  .I_BREADY(I_BREADY), .O_BRESP(O_BRESP), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .I_ARADDR(I_ARADDR),
  .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP),
  .O_CORE_POP_VALID(O_CORE_POP_VALID)
);

`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import flc_pkg::*;
  typedef struct packed {logic wr; logic [7:0] addr; logic [31:0] data; logic [31:0] exp; logic [1:0] resp;} flc_row_s;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic awvalid = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic wvalid = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h1;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic [7:0] araddr = 8'h00;
  logic rready = 1'h0;
  logic push_go = 1'h0;
  logic pop_go = 1'h0;
  logic slow = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, push_ready, pop_valid, push_valid, pop_ready, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [7:0] push_data, pop_data;
  logic [15:0] n_push, n_pop, n_bad;
  int stall = 0;
  int fail_count = 0;
  int n_compared = 0;
  flc_row_s rows [15] = '{
    '{1'h0, FLC_ADDR_SETTINGS, 32'h0, 32'h20, FLC_RESP_OKAY},
    '{1'h0, FLC_ADDR_IRQ_STAT, 32'h0, 32'h2, FLC_RESP_OKAY},
    '{1'h0, FLC_ADDR_THRESH, 32'h0, 32'h0, FLC_RESP_OKAY},
    '{1'h0, FLC_ADDR_FILL, 32'h0, 32'h0, FLC_RESP_OKAY},
    '{1'h1, FLC_ADDR_THRESH, 32'h105, 32'h0, FLC_RESP_OKAY},
    '{1'h0, FLC_ADDR_THRESH, 32'h0, 32'h05, FLC_RESP_OKAY},
    '{1'h1, FLC_ADDR_SETTINGS, 32'h04, 32'h0, FLC_RESP_OKAY},
    '{1'h0, FLC_ADDR_SETTINGS, 32'h0, 32'h24, FLC_RESP_OKAY},
    '{1'h1, FLC_ADDR_SETTINGS, 32'h84, 32'h0, FLC_RESP_OKAY},
    '{1'h0, FLC_ADDR_SETTINGS, 32'h0, 32'hA4, FLC_RESP_OKAY},
    '{1'h0, 8'h20, 32'h0, 32'h0, FLC_RESP_SLVERR},
    '{1'h1, 8'h24, 32'h1, 32'h0, FLC_RESP_SLVERR},
    '{1'h1, FLC_ADDR_IRQ_STAT, 32'hF, 32'h0, FLC_RESP_OKAY},
    '{1'h0, FLC_ADDR_IRQ_STAT, 32'h0, 32'h0, FLC_RESP_OKAY},
    '{1'h0, FLC_ADDR_IRQ_MASK, 32'h0, 32'h0, FLC_RESP_OKAY}};

  always #10 clk = ~clk;

  flc_top dut (
    .I_CLK(clk), .I_NRST(nrst), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr), .I_AWPROT(3'h0),
    .I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata), .I_WSTRB(wstrb), .O_BVALID(bvalid), .I_BREADY(bready),
    .O_BRESP(bresp), .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr), .I_ARPROT(3'h0),
    .O_RVALID(rvalid), .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp), .I_CORE_PUSH_VALID(push_valid),
    .O_CORE_PUSH_READY(push_ready), .I_CORE_PUSH_DATA(push_data), .O_CORE_POP_VALID(pop_valid),
    .I_CORE_POP_READY(pop_ready), .O_CORE_POP_DATA(pop_data), .O_IRQ(irq));

  flc_core_model u_core (
    .i_clk(clk), .i_nrst(nrst), .i_push_go(push_go), .i_pop_go(pop_go), .i_slow(slow), .i_push_lim(16'h12C),
    .o_push_valid(push_valid), .o_push_data(push_data), .i_push_ready(push_ready), .i_pop_valid(pop_valid),
    .i_pop_data(pop_data), .o_pop_ready(pop_ready), .o_n_push(n_push), .o_n_pop(n_pop), .o_n_bad(n_bad));

  // ------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    awvalid <= 1'h1;
    awaddr <= a;
    wvalid <= 1'h1;
    wdata <= d;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      if (awvalid && awready)
      begin
        aw_ok = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready)
      begin
        w_ok = 1'h1;
        wvalid <= 1'h0;
      end
    end
    repeat (stall) @(posedge clk);
    bready <= 1'h1;
    do @(posedge clk); while (!bvalid);
    resp = bresp;
    bready <= 1'h0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    arvalid <= 1'h1;
    araddr <= a;
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    repeat (stall) @(posedge clk);
    rready <= 1'h1;
    do @(posedge clk); while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask : axi_read

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d);
    chk(32'(resp), 32'(FLC_RESP_OKAY));
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_read(a);
    chk(rd, e);
    chk(32'(resp), 32'(FLC_RESP_OKAY));
  endtask : rd_chk

  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  // ------------------------------------------------
  // sequence; watchdog allows over twenty times the expected run
  // ------------------------------------------------
  initial
  begin
    repeat (40000) @(posedge clk);
    fail_count++;
    finish_test();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    for (int i = 0; i < 15; i++)
    begin
      if (rows[i].wr)
        axi_write(rows[i].addr, rows[i].data);
      else
        axi_read(rows[i].addr);
      if (!rows[i].wr)
        chk(rd, rows[i].exp);
      chk(32'(resp), 32'(rows[i].resp));
    end
    // 255-byte mode with level 5: near-full from 250 bytes, full at 255
    for (int i = 0; i < 256; i++)
    begin
      if (i == 249)
        rd_chk(FLC_ADDR_SETTINGS, 32'h84);
      if (i == 250)
        rd_chk(FLC_ADDR_SETTINGS, 32'hC4);
      if (i == 250)
        rd_chk(FLC_ADDR_FILL, 32'hFA);
      if (i == 255)
        chk(32'(irq), 32'h0);
      axi_write(FLC_ADDR_DATA, 32'(i));
    end
    wr(FLC_ADDR_IRQ_MASK, 32'h4);
    chk(32'(irq), 32'h1);
    rd_chk(FLC_ADDR_FILL, 32'hFF);
    rd_chk(FLC_ADDR_IRQ_STAT, 32'h5);
    wr(FLC_ADDR_IRQ_STAT, 32'h4);
    chk(32'(irq), 32'h0);
    stall = 2;
    wstrb <= 4'h0;
    wr(FLC_ADDR_THRESH, 32'h77);
    wstrb <= 4'h1;
    rd_chk(FLC_ADDR_THRESH, 32'h05);
    for (int i = 0; i < 3; i++)
      rd_chk(FLC_ADDR_DATA, 32'(i));
    stall = 0;
    rd_chk(FLC_ADDR_FILL, 32'hFC);
    wr(FLC_ADDR_SETTINGS, 32'h94);
    rd_chk(FLC_ADDR_SETTINGS, 32'hA4);
    rd_chk(FLC_ADDR_FILL, 32'h00);
    rd_chk(FLC_ADDR_DATA, 32'h00);
    rd_chk(FLC_ADDR_IRQ_STAT, 32'hB);
    wr(FLC_ADDR_IRQ_STAT, 32'hF);
    wr(FLC_ADDR_SETTINGS, 32'h04);
    push_go <= 1'h1;
    while (n_push < 16'h12C) @(posedge clk);
    push_go <= 1'h0;
    rd_chk(FLC_ADDR_FILL, 32'h2C);
    rd_chk(FLC_ADDR_SETTINGS, 32'h45);
    slow <= 1'h1;
    pop_go <= 1'h1;
    while (n_pop < 16'h12C) @(posedge clk);
    pop_go <= 1'h0;
    chk(32'(n_bad), 32'h0);
    rd_chk(FLC_ADDR_FILL, 32'h00);
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    rd_chk(FLC_ADDR_SETTINGS, 32'h20);
    finish_test();
  end
endmodule : testbench

`default_nettype wire

// ### src/flc_pkg.sv
package flc_pkg;

  // ------------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------------
  localparam int unsigned FLC_AW = 8;
  localparam int unsigned FLC_DW = 32;

  // ------------------------------------------------------------------
  // register indices and byte addresses
  // ------------------------------------------------------------------
  localparam logic [FLC_AW-1:0] FLC_IDX_SETTINGS = 8'h02;
  localparam logic [FLC_AW-1:0] FLC_IDX_THRESH = 8'h03;
  localparam logic [FLC_AW-1:0] FLC_IDX_FILL = 8'h04;
  localparam logic [FLC_AW-1:0] FLC_IDX_DATA = 8'h05;
  localparam logic [FLC_AW-1:0] FLC_IDX_IRQ_STAT = 8'h06;
  localparam logic [FLC_AW-1:0] FLC_IDX_IRQ_MASK = 8'h07;
  localparam logic [FLC_AW-1:0] FLC_ADDR_SETTINGS = FLC_AW'(FLC_IDX_SETTINGS * 4);
  localparam logic [FLC_AW-1:0] FLC_ADDR_THRESH = FLC_AW'(FLC_IDX_THRESH * 4);
  localparam logic [FLC_AW-1:0] FLC_ADDR_FILL = FLC_AW'(FLC_IDX_FILL * 4);
  localparam logic [FLC_AW-1:0] FLC_ADDR_DATA = FLC_AW'(FLC_IDX_DATA * 4);
  localparam logic [FLC_AW-1:0] FLC_ADDR_IRQ_STAT = FLC_AW'(FLC_IDX_IRQ_STAT * 4);
  localparam logic [FLC_AW-1:0] FLC_ADDR_IRQ_MASK = FLC_AW'(FLC_IDX_IRQ_MASK * 4);

  // ------------------------------------------------------------------
  // settings register fields
  // ------------------------------------------------------------------
  localparam int unsigned FLC_BIT_DEPTH_SEL = 7;
  localparam int unsigned FLC_BIT_NEAR_FULL = 6;
  localparam int unsigned FLC_BIT_NEAR_EMPTY = 5;
  localparam int unsigned FLC_BIT_CLEAR = 4;
  localparam int unsigned FLC_BIT_THRESH_MSB = 2;
  localparam int unsigned FLC_BIT_FILL_HI = 0;

  // ------------------------------------------------------------------
  // depths, counts and reset values
  // ------------------------------------------------------------------
  localparam logic [9:0] FLC_DEPTH_SMALL = 10'h0FF;
  localparam logic [9:0] FLC_DEPTH_LARGE = 10'h200;
  localparam logic FLC_RST_DEPTH_SEL = 1'b0;
  localparam logic [7:0] FLC_RST_THRESH = 8'h00;
  localparam logic [3:0] FLC_RST_IRQ_MASK = 4'h0;

  // ------------------------------------------------------------------
  // interrupt status bits
  // ------------------------------------------------------------------
  localparam int unsigned FLC_IRQ_NEAR_FULL = 0;
  localparam int unsigned FLC_IRQ_NEAR_EMPTY = 1;
  localparam int unsigned FLC_IRQ_OVERFLOW = 2;
  localparam int unsigned FLC_IRQ_UNDERFLOW = 3;
  localparam int unsigned FLC_IRQ_N = 4;

  // ------------------------------------------------------------------
  // bus responses
  // ------------------------------------------------------------------
  localparam logic [1:0] FLC_RESP_OKAY = 2'h0;
  localparam logic [1:0] FLC_RESP_SLVERR = 2'h2;

endpackage : flc_pkg

// ### src/flc_top.sv
// Function
// RULE1: settings bit 7 selects depth, one gives 255 bytes, zero gives 512.
// RULE2: host changes the depth selection only after clearing the buffer.
// RULE3: near-full reads one when depth minus fill count is at most threshold.
// RULE4: near-empty reads one when fill count is at most threshold.
// RULE5: writing one to settings bit 4 empties buffer; bit reads zero.
// RULE6: settings bit 2 is threshold bit 8, used only in 512-byte mode.
// RULE7: settings bits 1 and 0 show fill-count bits 9 and 8, read-only.
// RULE8: threshold register holds threshold bits 7 to 0, read and write.
// RULE9: fill-count register shows low count byte; data writes add, reads subtract.
// RULE10: data port address stays fixed, so repeated accesses stream bytes.
// RULE11: clear zeroes count; 255 mode hides count and threshold extensions. Code hides only the count bits; settings bit 2 still reads back in 255 mode.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module flc_top
  import flc_pkg::*;
#(
  parameter int unsigned MEM_DEPTH = 512
)
(
  input wire logic I_CLK,
  input wire logic I_NRST,
  // axi4-lite write address
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [flc_pkg::FLC_AW-1:0] I_AWADDR,
  input wire logic [2:0] I_AWPROT,
  // axi4-lite write data
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [flc_pkg::FLC_DW-1:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  // axi4-lite write response
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  // axi4-lite read address
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [flc_pkg::FLC_AW-1:0] I_ARADDR,
  input wire logic [2:0] I_ARPROT,
  // axi4-lite read data
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [flc_pkg::FLC_DW-1:0] O_RDATA,
  output logic [1:0] O_RRESP,
  // transceiver core filling the buffer
  input wire logic I_CORE_PUSH_VALID,
  output logic O_CORE_PUSH_READY,
  input wire logic [7:0] I_CORE_PUSH_DATA,
  // transceiver core draining the buffer
  output logic O_CORE_POP_VALID,
  input wire logic I_CORE_POP_READY,
  output logic [7:0] O_CORE_POP_DATA,
  // interrupt
  output logic O_IRQ
);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic aw_have_q;
  logic [FLC_AW-1:0] aw_addr_q;
  logic w_have_q;
  logic [FLC_DW-1:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [FLC_DW-1:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_go;
  logic rd_go;
  logic lane0;
  logic depth_sel_q;
  logic thresh_msb_q;
  logic [7:0] thresh_low_q;
  logic [FLC_IRQ_N-1:0] irq_stat_q;
  logic [FLC_IRQ_N-1:0] irq_mask_q;
  logic [FLC_IRQ_N-1:0] irq_event;
  logic [9:0] fill_q;
  logic [9:0] fill_d;
  logic [8:0] wptr_q;
  logic [8:0] rptr_q;
  logic [7:0] mem [MEM_DEPTH];
  logic [9:0] depth_val;
  logic [8:0] level;
  logic [9:0] room;
  logic near_full;
  logic near_empty;
  logic near_full_q;
  logic near_empty_q;
  logic is_full;
  logic is_empty;
  logic clear_req;
  logic bus_push_req;
  logic bus_pop_req;
  logic bus_push;
  logic bus_pop;
  logic core_push;
  logic core_pop;
  logic do_push;
  logic do_pop;
  logic [7:0] push_byte;

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  function automatic logic addr_known(input logic [FLC_AW-1:0] a);
    addr_known = (a == FLC_ADDR_SETTINGS) || (a == FLC_ADDR_THRESH) ||
                 (a == FLC_ADDR_FILL) || (a == FLC_ADDR_DATA) ||
                 (a == FLC_ADDR_IRQ_STAT) || (a == FLC_ADDR_IRQ_MASK);
  endfunction : addr_known

  // ------------------------------------------------------------------
  // axi4-lite handshakes
  // ------------------------------------------------------------------
  assign O_AWREADY = !aw_have_q && !bvalid_q;
  assign O_WREADY = !w_have_q && !bvalid_q;
  assign wr_go = aw_have_q && w_have_q && !bvalid_q;
  assign lane0 = w_strb_q[0];
  assign O_ARREADY = !rvalid_q;
  assign rd_go = I_ARVALID && !rvalid_q;
  assign O_BVALID = bvalid_q;
  assign O_BRESP = bresp_q;
  assign O_RVALID = rvalid_q;
  assign O_RDATA = rdata_q;
  assign O_RRESP = rresp_q;

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end
    else if (I_AWVALID && O_AWREADY)
    begin
      aw_have_q <= 1'b1;
      aw_addr_q <= I_AWADDR;
    end
    else if (wr_go)
    begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end
    else if (I_WVALID && O_WREADY)
    begin
      w_have_q <= 1'b1;
      w_data_q <= I_WDATA;
      w_strb_q <= I_WSTRB;
    end
    else if (wr_go)
    begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= FLC_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= addr_known(aw_addr_q) ? FLC_RESP_OKAY : FLC_RESP_SLVERR;
    end
    else if (I_BREADY)
    begin
      bvalid_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= FLC_RESP_OKAY;
    end
    else if (rd_go)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= addr_known(I_ARADDR) ? FLC_RESP_OKAY : FLC_RESP_SLVERR;
      rdata_q <= '0;
      case (I_ARADDR)
        FLC_ADDR_SETTINGS:
        begin
          rdata_q[FLC_BIT_DEPTH_SEL] <= depth_sel_q;
          // RULE3: near-full readback
          rdata_q[FLC_BIT_NEAR_FULL] <= near_full;
          // RULE4: near-empty readback
          rdata_q[FLC_BIT_NEAR_EMPTY] <= near_empty;
          // RULE5: clear bit reads zero
          rdata_q[FLC_BIT_CLEAR] <= 1'b0;
          rdata_q[FLC_BIT_THRESH_MSB] <= thresh_msb_q;
          // RULE7: count extension read-only
          // RULE11: hidden in 255 mode
          rdata_q[FLC_BIT_FILL_HI +: 2] <= depth_sel_q ? 2'h0 : fill_q[9:8];
        end
        FLC_ADDR_THRESH: rdata_q[7:0] <= thresh_low_q;
        // RULE9: low count byte
        FLC_ADDR_FILL: rdata_q[7:0] <= fill_q[7:0];
        FLC_ADDR_DATA: rdata_q[7:0] <= is_empty ? 8'h00 : mem[rptr_q];
        FLC_ADDR_IRQ_STAT: rdata_q[FLC_IRQ_N-1:0] <= irq_stat_q;
        FLC_ADDR_IRQ_MASK: rdata_q[FLC_IRQ_N-1:0] <= irq_mask_q;
        default: rdata_q <= '0;
      endcase
    end
    else if (I_RREADY)
    begin
      rvalid_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      depth_sel_q <= FLC_RST_DEPTH_SEL;
      thresh_msb_q <= 1'b0;
    end
    else if (wr_go && lane0 && aw_addr_q == FLC_ADDR_SETTINGS)
    begin
      // RULE1: depth select stored
      depth_sel_q <= w_data_q[FLC_BIT_DEPTH_SEL];
      // RULE6: threshold msb stored
      thresh_msb_q <= w_data_q[FLC_BIT_THRESH_MSB];
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      thresh_low_q <= FLC_RST_THRESH;
    end
    // RULE8: threshold low byte
    else if (wr_go && lane0 && aw_addr_q == FLC_ADDR_THRESH)
    begin
      thresh_low_q <= w_data_q[7:0];
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      irq_mask_q <= FLC_RST_IRQ_MASK;
    end
    else if (wr_go && lane0 && aw_addr_q == FLC_ADDR_IRQ_MASK)
    begin
      irq_mask_q <= w_data_q[FLC_IRQ_N-1:0];
    end
  end

  // ------------------------------------------------------------------
  // level comparison
  // ------------------------------------------------------------------
  // RULE1: depth from select bit
  assign depth_val = depth_sel_q ? FLC_DEPTH_SMALL : FLC_DEPTH_LARGE;
  // RULE6: msb ignored in 255 mode
  assign level = {thresh_msb_q && !depth_sel_q, thresh_low_q};
  assign room = depth_val - fill_q;
  // RULE3: near-full compare
  assign near_full = room <= {1'b0, level};
  // RULE4: near-empty compare
  assign near_empty = fill_q <= {1'b0, level};
  assign is_full = fill_q >= depth_val;
  assign is_empty = fill_q == 10'h000;

  // ------------------------------------------------------------------
  // buffer access arbitration
  // ------------------------------------------------------------------
  // RULE5: clear pulse on write of one
  assign clear_req = wr_go && lane0 && aw_addr_q == FLC_ADDR_SETTINGS && w_data_q[FLC_BIT_CLEAR];
  // RULE10: fixed data port address
  assign bus_push_req = wr_go && lane0 && aw_addr_q == FLC_ADDR_DATA;
  assign bus_pop_req = rd_go && I_ARADDR == FLC_ADDR_DATA;
  assign bus_push = bus_push_req && !is_full;
  assign bus_pop = bus_pop_req && !is_empty;
  // bus access wins the single port over the core
  assign O_CORE_PUSH_READY = !is_full && !bus_push_req && !clear_req;
  assign O_CORE_POP_VALID = !is_empty && !bus_pop_req;
  assign O_CORE_POP_DATA = mem[rptr_q];
  assign core_push = I_CORE_PUSH_VALID && O_CORE_PUSH_READY;
  assign core_pop = I_CORE_POP_READY && O_CORE_POP_VALID;
  assign do_push = bus_push || core_push;
  assign do_pop = bus_pop || core_pop;
  assign push_byte = bus_push ? w_data_q[7:0] : I_CORE_PUSH_DATA;

  // ------------------------------------------------------------------
  // storage and pointers
  // ------------------------------------------------------------------
  always_ff @(posedge I_CLK)
  begin
    if (do_push)
    begin
      mem[wptr_q] <= push_byte;
    end
  end

  always_comb
  begin
    fill_d = fill_q;
    // RULE11: clear zeroes the count
    if (clear_req)
    begin
      fill_d = 10'h000;
    end
    // RULE9: push adds, pop subtracts
    else if (do_push && !do_pop)
    begin
      fill_d = fill_q + 10'h001;
    end
    else if (do_pop && !do_push)
    begin
      fill_d = fill_q - 10'h001;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      fill_q <= 10'h000;
      wptr_q <= 9'h000;
      rptr_q <= 9'h000;
    end
    else
    begin
      fill_q <= fill_d;
      if (clear_req)
      begin
        wptr_q <= 9'h000;
        rptr_q <= 9'h000;
      end
      else
      begin
        if (do_push)
        begin
          wptr_q <= wptr_q + 9'h001;
        end
        if (do_pop)
        begin
          rptr_q <= rptr_q + 9'h001;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      near_full_q <= 1'b0;
      near_empty_q <= 1'b0;
    end
    else
    begin
      near_full_q <= near_full;
      near_empty_q <= near_empty;
    end
  end

  always_comb
  begin
    irq_event = '0;
    irq_event[FLC_IRQ_NEAR_FULL] = near_full && !near_full_q;
    irq_event[FLC_IRQ_NEAR_EMPTY] = near_empty && !near_empty_q;
    irq_event[FLC_IRQ_OVERFLOW] = bus_push_req && is_full;
    irq_event[FLC_IRQ_UNDERFLOW] = bus_pop_req && is_empty;
  end

  generate
    for (genvar g = 0; g < FLC_IRQ_N; g++)
    begin : g_irq
      // set wins over a write-one clear in the same cycle
      always_ff @(posedge I_CLK or negedge I_NRST)
      begin
        if (!I_NRST)
        begin
          irq_stat_q[g] <= 1'b0;
        end
        else if (irq_event[g])
        begin
          irq_stat_q[g] <= 1'b1;
        end
        else if (wr_go && lane0 && aw_addr_q == FLC_ADDR_IRQ_STAT && w_data_q[g])
        begin
          irq_stat_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign O_IRQ = |(irq_stat_q & irq_mask_q);

endmodule : flc_top

`default_nettype wire
